// File: shared/dcpwm_defines.svh
// Offsets, field positions, reset values and counts of the two-channel
// PWM counter. Included by the package and the design; definitions only.
`ifndef DCPWM_DEFINES_SVH
`define DCPWM_DEFINES_SVH

// Register byte offsets on the APB bus
`define DCPWM_OFF_CSC 8'h00
`define DCPWM_OFF_CNT 8'h04
`define DCPWM_OFF_LIMH 8'h08
`define DCPWM_OFF_LIML 8'h0C
`define DCPWM_OFF_C0CTL 8'h10
`define DCPWM_OFF_C0CMP 8'h14
`define DCPWM_OFF_C1CTL 8'h18
`define DCPWM_OFF_C1CMP 8'h1C

// Counter status and control bit positions
`define DCPWM_CSC_FLAG 7
`define DCPWM_CSC_IE 6
`define DCPWM_CSC_HALT 5
`define DCPWM_CSC_CLR 4

// Channel control bit positions
`define DCPWM_CH_FLAG 7

// Reset values
`define DCPWM_CSC_RESET 8'h20
`define DCPWM_LIM_RESET 8'hFF

// Prescaler: six bits give divide by up to 64, code 7 gives no tick
`define DCPWM_PRE_W 6
`define DCPWM_PS_OFF 3'h7

`endif

// File: shared/dcpwm_pkg.sv
// Types of the two-channel PWM counter: control fields and full state.
// Needs dcpwm_defines.svh on the include path.
`include "dcpwm_defines.svh"

package dcpwm_pkg;

    // Counter status and control fields, laid out as the register reads
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic halt;
        logic clr;
        logic zero;
        logic [2:0] div;
    } dcpwm_csc_t;

    // Channel status and control fields, laid out as the register reads
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic [1:0] mode;
        logic [1:0] act;
        logic tov;
        logic full;
    } dcpwm_ch_t;

    // Whole state of the block
    typedef struct packed {
        dcpwm_csc_t csc;
        logic wrap_armed;
        logic wrap_inhibit;
        logic [`DCPWM_PRE_W-1:0] pre;
        logic [15:0] cnt;
        logic [7:0] lim_hi;
        logic [7:0] lim_lo;
        dcpwm_ch_t [1:0] ch;
        logic [1:0] ch_armed;
        logic [1:0][15:0] cmp;
        logic pair_active;
        logic pair_last;
        logic [1:0] pin;
        logic [1:0] pin_oe;
        logic irq;
        logic wake;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dcpwm_state_t;

endpackage

// File: verilog/dcpwm_top.sv
// Two-channel PWM counter with an APB register slave.
// Assumes one 200 MHz clock pclk, asynchronous active-low presetn, and
// wait and stop indications driven by logic on the same clock.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "dcpwm_defines.svh"

module dcpwm_top
    import dcpwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic first_channel_pin,
    output logic first_channel_pin_oe,
    output logic second_channel_pin,
    output logic second_channel_pin_oe,
    output logic irq_req,
    output logic wake_req
);

    dcpwm_state_t s_q; // Registered state
    dcpwm_state_t s_d; // Next state

    // Values decoded from the state in every cycle
    logic [15:0] limit; // Period limit from its two bytes
    logic [`DCPWM_PRE_W-1:0] pre_mask; // Prescaler terminal pattern
    logic running; // Counter may advance
    logic tick; // Prescaled timer clock enable
    logic wrap; // Counter at limit on a tick
    logic [15:0] cnt_nx; // Counter value after the tick
    logic link; // Channels joined into one buffered output
    logic [1:0][15:0] cmp_eff; // Compare value each channel uses
    logic [1:0] ch_use; // Channel acts as an output compare
    logic [1:0] match; // Compare match this tick
    logic setup; // APB setup cycle
    logic acc; // APB access cycle that completes
    logic wr; // Completing, accepted write
    logic rd; // Completing, accepted read
    logic mapped; // Address names a register
    logic [31:0] rdat; // Read data of the addressed register

    // The prescaler is a free binary count; a tick comes when its low
    // bits, as many as the divider code, are all ones. Code 7 never
    // ticks, so the counter simply stands.
    // Limit, prescaler pattern and tick generation
    always_comb begin
        // The limit is split in two bytes for byte-wide software
        limit = {s_q.lim_hi, s_q.lim_lo};
        pre_mask = `DCPWM_PRE_W'((7'h01 << s_q.csc.div) - 7'h01);
        running = ~s_q.csc.halt & ~stop_mode;
        tick = running & (s_q.csc.div != `DCPWM_PS_OFF)
            & ((s_q.pre & pre_mask) == pre_mask);
        wrap = tick & (s_q.cnt == limit);
        cnt_nx = (s_q.cnt == limit) ? 16'h0000 : s_q.cnt + 16'h0001;
    end

    // Matching on the value the counter is about to take lets the pin
    // register change on the same edge as the counter, so the pin and
    // the count never disagree by a cycle.
    // Unlinked, a new compare value is used from the next tick on; a value the
    // counter has already passed waits for the next period.
    // Active compare values and match detection
    always_comb begin
        link = s_q.ch[0].mode[1];
        cmp_eff[0] = (link & s_q.pair_active) ? s_q.cmp[1] : s_q.cmp[0];
        cmp_eff[1] = s_q.cmp[1];
        ch_use[0] = s_q.ch[0].mode != 2'b00;
        // Channel one drops out while folded into the pair
        ch_use[1] = (s_q.ch[1].mode != 2'b00) & ~link;
        for (int i = 0; i < 2; i++) begin
            // Equality on the value the counter now takes
            match[i] = tick & ch_use[i] & (cnt_nx == cmp_eff[i]);
        end
    end

    // The slave answers every transfer with exactly one access cycle:
    // read data and the error are captured in the setup cycle, so the
    // access cycle needs no further decode on the read side.
    // Wait mode closes every register, so a sleeping core cannot
    // disturb a running waveform.
    // APB phase decode and register read mux
    always_comb begin
        setup = psel & ~penable;
        acc = psel & penable & s_q.pready;
        wr = acc & pwrite & ~s_q.pslverr;
        rd = acc & ~pwrite & ~s_q.pslverr;
        mapped = 1'b1;
        rdat = 32'h0000_0000;
        case (paddr)
            `DCPWM_OFF_CSC: begin
                rdat[7:0] = {s_q.csc.flag, s_q.csc.irq_en, s_q.csc.halt,
                    1'b0, 1'b0, s_q.csc.div};
            end
            `DCPWM_OFF_CNT: begin
                rdat[15:0] = s_q.cnt;
            end
            `DCPWM_OFF_LIMH: begin
                rdat[7:0] = s_q.lim_hi;
            end
            `DCPWM_OFF_LIML: begin
                rdat[7:0] = s_q.lim_lo;
            end
            `DCPWM_OFF_C0CTL: begin
                rdat[7:0] = s_q.ch[0];
            end
            `DCPWM_OFF_C0CMP: begin
                rdat[15:0] = s_q.cmp[0];
            end
            `DCPWM_OFF_C1CTL: begin
                rdat[7:0] = s_q.ch[1];
            end
            `DCPWM_OFF_C1CMP: begin
                rdat[15:0] = s_q.cmp[1];
            end
            default: begin
                mapped = 1'b0; // Unmapped: error, reads zero
            end
        endcase
    end

    // All state changes meet here. Order matters: the counter steps first, then
    // clears and software writes, flag sets and pin actions last, so a flag event
    // that lands in the same cycle as a flag clear always wins.
    // Next-state logic for counter, flags, pins and bus answer
    always_comb begin
        // Hold everything unless a branch below says otherwise
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;

        // Prescaler and counter
        // Stop mode and the halt bit both freeze the prescaler
        if (running) begin
            s_d.pre = s_q.pre + `DCPWM_PRE_W'(1);
        end
        if (tick) begin
            s_d.cnt = cnt_nx;
        end

        // Wrap flag: an overflow cancels a pending clear
        if (wrap) begin
            s_d.wrap_armed = 1'b0;
        end

        // The pair written last takes over only at a wrap, so a width
        // change never cuts a pulse short in the middle of a period.
        // Pair switch-over at each wrap
        if (!link) begin
            s_d.pair_active = 1'b0;
            s_d.pair_last = 1'b0;
        end else if (wrap) begin
            s_d.pair_active = s_q.pair_last;
        end

        // Channel match flags; a match cancels a pending clear
        for (int i = 0; i < 2; i++) begin
            if (match[i]) begin
                s_d.ch_armed[i] = 1'b0;
            end
        end

        // Setup cycle: latch read data and answer for the access cycle
        if (setup) begin
            s_d.pready = 1'b1;
            s_d.pslverr = ~mapped | wait_mode;
            s_d.prdata = (mapped & ~wait_mode) ? rdat : 32'h0000_0000;
        end

        // Reading a status register with its flag set arms the clear
        // An event in the same cycle as the read leaves it unarmed
        if (rd && paddr == `DCPWM_OFF_CSC && s_q.prdata[`DCPWM_CSC_FLAG]) begin
            s_d.wrap_armed = ~wrap;
        end
        // Same two-step clear for each channel flag
        for (int i = 0; i < 2; i++) begin
            if (rd && s_q.prdata[`DCPWM_CH_FLAG] && paddr ==
                ((i == 0) ? `DCPWM_OFF_C0CTL : `DCPWM_OFF_C1CTL)) begin
                s_d.ch_armed[i] = ~match[i];
            end
        end

        // Writes land on the access edge only; a refused transfer has
        // pslverr set and never reaches this point.
        // Register writes
        if (wr) begin
            case (paddr)
                `DCPWM_OFF_CSC: begin
                    s_d.csc.irq_en = pwdata[`DCPWM_CSC_IE];
                    s_d.csc.halt = pwdata[`DCPWM_CSC_HALT];
                    s_d.csc.div = pwdata[2:0];
                    if (!pwdata[`DCPWM_CSC_FLAG] && s_q.wrap_armed && !wrap) begin
                        s_d.csc.flag = 1'b0;
                        s_d.wrap_armed = 1'b0;
                    end
                    // Clear bit is not stored: it acts once, reads zero
                    if (pwdata[`DCPWM_CSC_CLR]) begin
                        s_d.cnt = 16'h0000;
                        s_d.pre = '0;
                    end
                end
                `DCPWM_OFF_LIMH: begin
                    s_d.lim_hi = pwdata[7:0];
                    // Counter still wraps; only the flag waits
                    s_d.wrap_inhibit = 1'b1;
                end
                `DCPWM_OFF_LIML: begin
                    s_d.lim_lo = pwdata[7:0];
                    s_d.wrap_inhibit = 1'b0;
                end
                `DCPWM_OFF_C0CTL, `DCPWM_OFF_C1CTL: begin
                    for (int i = 0; i < 2; i++) begin
                        if (paddr == ((i == 0) ? `DCPWM_OFF_C0CTL
                            : `DCPWM_OFF_C1CTL)) begin
                            s_d.ch[i][6:0] = pwdata[6:0];
                            if (!pwdata[`DCPWM_CH_FLAG] && s_q.ch_armed[i]
                                && !match[i]) begin
                                s_d.ch[i].flag = 1'b0;
                                s_d.ch_armed[i] = 1'b0;
                            end
                        end
                    end
                end
                `DCPWM_OFF_C0CMP: begin
                    s_d.cmp[0] = pwdata[15:0];
                    s_d.pair_last = 1'b0;
                end
                `DCPWM_OFF_C1CMP: begin
                    s_d.cmp[1] = pwdata[15:0];
                    s_d.pair_last = link;
                end
                default: begin
                    // Counter register is read-only
                    s_d.cnt = s_d.cnt; // Read-only or unmapped: no effect
                end
            endcase
        end

        // Event flags: hardware set wins over any clear above
        if (wrap && !s_q.wrap_inhibit) begin
            s_d.csc.flag = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (match[i]) begin
                s_d.ch[i].flag = 1'b1;
            end
        end

        // Toggle at the wrap starts the pulse, the compare force ends
        // it. Without the toggle the force keeps hitting the level that
        // is already there, which gives a steady 0% output.
        // A released pin (action 00 or idle channel) is not driven; an idle
        // channel keeps its last level, under action 00 toggle and hold still act.
        // Pin actions: toggle at wrap, then compare forces the pin
        for (int i = 0; i < 2; i++) begin
            if (ch_use[i]) begin
                if (wrap && s_q.ch[i].tov) begin
                    s_d.pin[i] = ~s_q.pin[i];
                end
                if (match[i]) begin
                    case (s_q.ch[i].act)
                        2'b01: s_d.pin[i] = ~s_d.pin[i];
                        2'b10: s_d.pin[i] = 1'b0;
                        2'b11: s_d.pin[i] = 1'b1;
                        default: s_d.pin[i] = s_d.pin[i];
                    endcase
                end
                if (s_q.ch[i].full && s_q.ch[i].tov) begin
                    // Hold the pulse level: opposite of the compare force
                    s_d.pin[i] = ~s_q.ch[i].act[0];
                end
            end
            // Channel one lets go of its pin while linked
            s_d.pin_oe[i] = ch_use[i] & (s_q.ch[i].act != 2'b00);
        end

        // The request follows the flags one cycle late; channel one
        // cannot request while it is folded into the pair.
        // Interrupt request and wake indication
        s_d.irq = (s_q.csc.flag & s_q.csc.irq_en)
            | (s_q.ch[0].flag & s_q.ch[0].irq_en)
            | (s_q.ch[1].flag & s_q.ch[1].irq_en & ~link);
        // Wake only matters while the core sleeps
        s_d.wake = s_d.irq & wait_mode;
    end

    // Reset brings the counter to a halt with the limit at all ones,
    // so nothing moves until software has set the block up.
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.csc <= `DCPWM_CSC_RESET;
            s_q.lim_hi <= `DCPWM_LIM_RESET;
            s_q.lim_lo <= `DCPWM_LIM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    // No logic between the state register and the pins
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign first_channel_pin = s_q.pin[0];
    assign first_channel_pin_oe = s_q.pin_oe[0];
    assign second_channel_pin = s_q.pin[1];
    assign second_channel_pin_oe = s_q.pin_oe[1];
    assign irq_req = s_q.irq;
    assign wake_req = s_q.wake;

endmodule

// File: test/dcpwm_load.sv
// Load on a channel pin: measures PWM period and high time.
// Assumes a pull-down on the line and the design's clock.
`timescale 1ns/1ps

module dcpwm_load (
    input wire logic pclk,
    input wire logic pin,
    input wire logic oe,
    output logic [15:0] period,
    output logic [15:0] high_len
);
    logic lvl; // Line level seen by the load
    logic lvl_q = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] hcnt = 16'h0000;

    // A released line is pulled low
    assign lvl = oe & pin;

    // Latch spacing and high time at each rising edge
    always @(posedge pclk) begin
        lvl_q <= lvl;
        cnt <= cnt + 16'h0001;
        hcnt <= hcnt + {15'h0000, lvl};
        if (lvl && !lvl_q) begin
            period <= cnt;
            high_len <= hcnt;
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
        end
    end
endmodule

// File: test/dcpwm_sva.sv
// Checker of the PWM counter, bound to its top module.
// Assumes one clock pclk and asynchronous active-low presetn.
`timescale 1ns/1ps

module dcpwm_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic first_channel_pin,
    input wire logic first_channel_pin_oe,
    input wire logic second_channel_pin_oe,
    input wire logic irq_req,
    input wire logic wake_req
);
    logic [7:0] ctl0_q; // Channel 0 control as last accepted

    // Follow accepted writes to channel 0 control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_q <= 8'h00;
        end else if (psel && penable && pready && pwrite && !pslverr
                && paddr == 8'h10) begin
            ctl0_q <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Setup phase, and a settled stop with no write
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_frozen;
        (stop_mode && !(psel && pwrite))[*2];
    endsequence

    a_setup_ready: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_wait_closed: assert property (
        s_setup ##0 wait_mode |=> pslverr)
        else $error("access in wait mode not refused");
    a_wake_match: assert property (
        wake_req == (irq_req && $past(wait_mode)))
        else $error("wake request wrong");
    a_stop_hold: assert property (s_frozen |-> $stable(first_channel_pin))
        else $error("pin moved in stop mode");
    a_zero_hold: assert property (
        (ctl0_q[5:0] == 6'h18)[*3] ##0 !first_channel_pin
        |=> !first_channel_pin)
        else $error("pin rose without toggle");
    a_full_level: assert property (
        (ctl0_q[1:0] == 2'b11 && ctl0_q[5:4] != 2'b00)[*3]
        |-> first_channel_pin == !ctl0_q[2])
        else $error("full duty level wrong");
    a_drive_on: assert property (
        (ctl0_q[5:4] != 2'b00 && ctl0_q[3:2] != 2'b00)[*2]
        |-> first_channel_pin_oe)
        else $error("pin 0 not driven");
    a_link_free: assert property ((ctl0_q[5])[*2] |-> !second_channel_pin_oe)
        else $error("pin 1 driven while linked");
endmodule

bind dcpwm_top dcpwm_sva chk_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .wait_mode(wait_mode),
    .stop_mode(stop_mode),
    .first_channel_pin(first_channel_pin),
    .first_channel_pin_oe(first_channel_pin_oe),
    .second_channel_pin_oe(second_channel_pin_oe),
    .irq_req(irq_req),
    .wake_req(wake_req)
);

// File: test/dcpwm_tb_top.sv
// Self-checking bench of the PWM counter over APB.
// Assumes design, load model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
end

module dcpwm_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic [31:0] prdata, rd, c;
    logic pready, pslverr, err, irq_req, wake_req;
    logic first_channel_pin, first_channel_pin_oe;
    logic second_channel_pin, second_channel_pin_oe;
    logic [15:0] period, high_len, period1, high1;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    dcpwm_top dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .wait_mode(wait_mode),
        .stop_mode(stop_mode),
        .first_channel_pin(first_channel_pin),
        .first_channel_pin_oe(first_channel_pin_oe),
        .second_channel_pin(second_channel_pin),
        .second_channel_pin_oe(second_channel_pin_oe),
        .irq_req(irq_req),
        .wake_req(wake_req)
    );

    // Second load on the channel one pin
    dcpwm_load load1_u (
        .pclk(pclk),
        .pin(second_channel_pin),
        .oe(second_channel_pin_oe),
        .period(period1),
        .high_len(high1)
    );

    dcpwm_load load_u (
        .pclk(pclk),
        .pin(first_channel_pin),
        .oe(first_channel_pin_oe),
        .period(period),
        .high_len(high_len)
    );

    // One APB transfer, held until pready
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // Halt and clear, limit, compare, mode, then run
    task automatic pwm_init(input logic [15:0] lim, input logic [15:0] cmp,
            input logic [7:0] ctl, input logic [2:0] div);
        xfer(1'b1, 8'h00, 32'h30);
        xfer(1'b1, 8'h08, {24'h0, lim[15:8]});
        xfer(1'b1, 8'h0C, {24'h0, lim[7:0]});
        xfer(1'b1, 8'h14, {16'h0, cmp});
        xfer(1'b1, 8'h10, {24'h0, ctl});
        xfer(1'b1, 8'h00, {29'h0, div});
    endtask

    task automatic test_done;
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_rd(8'h00, 32'h20);
        chk_rd(8'h0C, 32'hFF);
        xfer(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        pwm_init(16'h00FF, 16'h0080, 8'h1A, 3'h0);
        repeat (1100) @(posedge pclk);
        `CHK(period, 16'h0100)
        `CHK(high_len, 16'h0080)
        chk_rd(8'h10, 32'h9A);
        chk_rd(8'h00, 32'h80);
        xfer(1'b1, 8'h00, 32'h0);
        // Longer width is written just after a wrap has been flagged
        do xfer(1'b0, 8'h00, 32'h0); while (rd[7] !== 1'b1);
        xfer(1'b1, 8'h14, 32'hA0);
        repeat (600) @(posedge pclk);
        `CHK(high_len, 16'h00A0)
        chk_rd(8'h00, 32'h80);
        xfer(1'b1, 8'h00, 32'h20);
        chk_rd(8'h00, 32'h20);
        // Wait mode: counting goes on, bus closed, wake raised
        xfer(1'b1, 8'h00, 32'h40);
        wait_mode <= 1'b1;
        repeat (300) @(posedge pclk);
        `CHK({irq_req, wake_req}, 2'b11)
        xfer(1'b0, 8'h00, 32'h0);
        `CHK(err, 1'b1)
        wait_mode <= 1'b0;
        // Stop mode freezes the count
        stop_mode <= 1'b1;
        xfer(1'b0, 8'h04, 32'h0);
        c = rd;
        repeat (40) @(posedge pclk);
        chk_rd(8'h04, c);
        stop_mode <= 1'b0;
        xfer(1'b1, 8'h00, 32'h30);
        chk_rd(8'h04, 32'h0);
        xfer(1'b0, 8'h00, 32'h0);
        `CHK(rd[6:0], 7'h20)
        // Zero duty, then full duty
        pwm_init(16'h00FF, 16'h0080, 8'h18, 3'h0);
        repeat (300) @(posedge pclk);
        `CHK(first_channel_pin, 1'b0)
        xfer(1'b1, 8'h10, 32'h1B);
        repeat (4) @(posedge pclk);
        `CHK(first_channel_pin, 1'b1)
        // Divider codes 0 to 6 stretch period and width alike
        for (int d = 0; d < 7; d++) begin
            pwm_init(16'h000F, 16'h0008, 8'h1A, 3'(d));
            repeat (80 << d) @(posedge pclk);
            `CHK(period, 16'h0010 << d)
            `CHK(high_len, 16'h0008 << d)
        end
        // Channel one, pulse level low: set on compare, low for 4 ticks
        xfer(1'b1, 8'h00, 32'h0);
        xfer(1'b1, 8'h1C, 32'h4);
        xfer(1'b1, 8'h18, 32'h1E);
        repeat (3) @(posedge pclk);
        `CHK(second_channel_pin_oe, 1'b1)
        repeat (70) @(posedge pclk);
        `CHK(period1, 16'h0010)
        `CHK(high1, 16'h000C)
        // Linked pair: last written compare governs from next wrap
        pwm_init(16'h00FF, 16'h0080, 8'h2A, 3'h0);
        xfer(1'b1, 8'h1C, 32'h40);
        repeat (1100) @(posedge pclk);
        `CHK(high_len, 16'h0040)
        `CHK(second_channel_pin_oe, 1'b0)
        xfer(1'b1, 8'h14, 32'hC8);
        repeat (800) @(posedge pclk);
        `CHK(high_len, 16'h00C8)
        test_done();
    end
endmodule
